// >>> hdl/acq_trig_pkg.sv
package acq_trig_pkg;

  // widths
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;
  localparam int CNT_W    = 24;
  localparam int CTRL_W   = 12;
  localparam int SAMPLE_W = 8;
  localparam int DIV_W    = 7;

  // register offsets (byte addresses)
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_THRESH   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_START    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_LENGTH   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_POSTTRIG = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FINEDLY  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_SWTRIG   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_CAPTURE  = 8'h20;

  // status bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_TRIG = 1;
  localparam int STAT_WRAP = 2;

  // counter constants
  localparam logic [CNT_W-1:0] START_ALIGN_MASK = 24'hfffffc;
  localparam logic [CNT_W-1:0] PAIR_STEP        = 24'h000002;
  localparam logic [CNT_W-1:0] CNT_ONE          = 24'h000001;
  localparam logic [7:0]       FD_ONE           = 8'h01;
  localparam int               FD_SHIFT_MSB     = 15;
  localparam int               FD_SHIFT_LSB     = 8;

  // trigger source kinds and analog sources
  typedef enum logic [1:0] {KIND_SOFT, KIND_ANALOG, KIND_DIGITAL} trig_kind_t;
  typedef enum logic [1:0] {SRC_CHAN_A, SRC_CHAN_B, SRC_TRIG_IN} ana_src_t;

  // control word, bit 0 is aboutMode
  typedef struct packed {
    logic [2:0] divSel;
    logic       extPacer;
    logic       fineDelayMode;
    ana_src_t   anaSrc;
    logic       levelMode;
    logic       negPol;
    trig_kind_t kind;
    logic       aboutMode;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '0;

  // register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  // buffer memory write, one sample pair per write
  typedef struct packed {
    logic                  we;
    logic [CNT_W-1:0]      addr;
    logic [2*SAMPLE_W-1:0] data;
  } mem_wr_t;

  typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_RUN, ST_PRE, ST_POST} acq_state_t;

  // whole state of the control core
  typedef struct packed {
    acq_state_t            st;
    ctrl_t                 ctrl;
    logic [7:0]            thresh;
    logic [7:0]            fineDelay;
    logic [CNT_W-1:0]      startCnt;
    logic [CNT_W-1:0]      lenCnt;
    logic [CNT_W-1:0]      postCnt;
    logic [CNT_W-1:0]      capture;
    logic [7:0]            fdCnt;
    logic                  fdPend;
    logic                  fdRun;
    logic                  fdFire;
    logic                  armFirst;
    logic                  wrapSeen;
    logic                  trigSeen;
    logic                  pendTrig;
    logic                  prevAbove;
    logic                  prevPin;
    logic                  prevExt;
    logic                  half;
    logic [SAMPLE_W-1:0]   firstSample;
    logic                  trigLine;
    logic                  pinOut;
    logic                  pinOeN;
    logic                  doneEv;
    mem_wr_t               mem;
    logic [DATA_W-1:0]     rdata;
  } core_state_t;

  localparam core_state_t CORE_RESET = '0;

endpackage : acq_trig_pkg

// >>> hdl/trigger_sync.sv
`timescale 1ns/1ps
module trigger_sync (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // asynchronous level in, clean level out
  input  wire logic asyncIn,
  output logic      syncOut
);

  logic stage1;

  // two flops, first one feeds only the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stage1  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : trigger_sync

// >>> hdl/pacer_divider.sv
`timescale 1ns/1ps
module pacer_divider (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // divide select 2**divSel, restart realigns the phase
  input  wire logic [2:0] divSel,
  input  wire logic       restart,
  // one-cycle pacer pulse
  output logic            tick
);

  logic [acq_trig_pkg::DIV_W-1:0] cnt;
  logic [7:0]                     span;
  logic [acq_trig_pkg::DIV_W-1:0] mask;

  // low bits all ones mark the last cycle of a period
  assign span = 8'h01 << divSel;
  assign mask = acq_trig_pkg::DIV_W'(span - 8'h01);
  assign tick = ((cnt & mask) == mask);

  // free count, cleared on restart
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt <= '0;
    end else if (restart) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 7'h01;
    end
  end

endmodule : pacer_divider

// >>> hdl/acquisition_trigger_control.sv
`timescale 1ns/1ps
// Function
// - positive-edge analog mode: trigger on crossing from below to above threshold
// - negative-edge analog mode: trigger on crossing from above to below threshold
// - positive-level mode: trigger at once if above threshold when acceptance opens
// - negative-level mode: trigger at once if below threshold when acceptance opens
// - analog source is channel A, channel B or trigger input; 8-bit threshold
// - trigger input threshold code spans 256 steps from -16 V to +15.875 V
// - analog trigger drives the pin: edge of polarity, inactive at acquisition end
// - digital mode takes the pin as input, trigger on programmed edge polarity
// - post mode: accepted trigger starts the post-trigger delay count
// - delay done releases start and length counters; start gives write addresses
// - length and post-trigger counters in sample pairs, start steps by two per pair; start loads with two low bits zero
// - writing the post-trigger counter arms; host writes it last
// - post mode writes one extra pair; start left addressing it
// - about mode samples into memory immediately on arming
// - about mode start counter increments throughout and wraps max to zero
// - about mode ignores triggers before the first start counter wrap
// - about trigger captures start counter and starts the length count
// - about mode ignores post-trigger value but still arms on its write
// - about-mode and fine-delay triggers are synchronised to the pacer before control logic uses them
// - post mode syncs trigger on undivided clock, then restarts the divider
// - fine-delay mode accepts only software triggers
// - fine-delay trigger is pacer-synchronous, delayed by fraction, driven on pin
// - internal pacer divides by 1, 2, 4 up to 128
// - length counter counts down; acquisition ends at zero
// - end of acquisition gives a pulse for the host interrupt
module acquisition_trigger_control (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  // register port
  input  wire acq_trig_pkg::reg_req_t   busReq,
  output logic [31:0]                   busRdata,
  // sample stream and comparator codes
  input  wire logic [7:0]               sampleA,
  input  wire logic [7:0]               sampleB,
  input  wire logic [7:0]               trigInCode,
  input  wire logic                     extPacer,
  // trigger pin
  input  wire logic                     trigPinIn,
  output logic                          trigPinOut,
  output logic                          trigPinOeN,
  // buffer memory
  output acq_trig_pkg::mem_wr_t         memWr,
  // status
  output logic                          busy,
  output logic                          acqDone
);

  acq_trig_pkg::core_state_t cur;
  acq_trig_pkg::core_state_t next_cur;

  logic        pinSync;
  logic        divTick;
  logic        divRestart;
  logic        pacerTick;
  logic        pairDone;
  logic [7:0]  anaCode;
  logic        above;
  logic        below;
  logic        anaEdge;
  logic        anaLevel;
  logic        digEdge;
  logic        swTrig;
  logic        kindTrig;
  logic        trigEv;
  logic        idle;
  logic        sampling;
  logic [15:0] fdSpan;
  logic [23:0] startInc;

  // pin synchroniser, pin is asynchronous to the pacer
  trigger_sync u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .asyncIn  (trigPinIn),
    .syncOut  (pinSync)
  );

  // internal pacer divider
  pacer_divider u_div (
    .core_clk (core_clk),
    .rst      (rst),
    .divSel   (cur.ctrl.divSel),
    .restart  (divRestart),
    .tick     (divTick)
  );

  // post-mode trigger taken on the undivided clock, divider realigned
  assign divRestart = (cur.st == acq_trig_pkg::ST_ARMED) && trigEv;

  // pacer: divided internal clock or rising edge of the external one
  assign pacerTick = (cur.ctrl.extPacer && !cur.ctrl.fineDelayMode) ?
                     (extPacer && !cur.prevExt) : divTick;
  assign pairDone  = pacerTick && cur.half;
  assign idle      = (cur.st == acq_trig_pkg::ST_IDLE);
  assign sampling  = (cur.st == acq_trig_pkg::ST_RUN) || (cur.st == acq_trig_pkg::ST_PRE)
                  || (cur.st == acq_trig_pkg::ST_POST);
  assign startInc  = cur.startCnt + acq_trig_pkg::PAIR_STEP;

  // analog source select; trigger input code 0 is -16 V, step 0.125 V
  always_comb begin
    unique case (cur.ctrl.anaSrc)
      acq_trig_pkg::SRC_CHAN_A:  anaCode = sampleA;
      acq_trig_pkg::SRC_CHAN_B:  anaCode = sampleB;
      acq_trig_pkg::SRC_TRIG_IN: anaCode = trigInCode;
      default:                   anaCode = trigInCode;
    endcase
  end

  // threshold comparison and analog trigger conditions
  assign above    = (anaCode > cur.thresh);
  assign below    = !above;
  assign anaEdge  = cur.ctrl.negPol ? (below && cur.prevAbove)
                                    : (above && !cur.prevAbove);
  assign anaLevel = cur.ctrl.levelMode && cur.armFirst &&
                    (cur.ctrl.negPol ? below : above);

  // digital edge on the synchronised pin
  assign digEdge  = cur.ctrl.negPol ? (!pinSync && cur.prevPin)
                                    : (pinSync && !cur.prevPin);

  assign swTrig   = busReq.wr && (busReq.addr == acq_trig_pkg::OFS_SWTRIG);

  // pick the trigger of the programmed kind
  always_comb begin
    unique case (cur.ctrl.kind)
      acq_trig_pkg::KIND_SOFT:    kindTrig = swTrig;
      acq_trig_pkg::KIND_ANALOG:  kindTrig = anaEdge || anaLevel;
      acq_trig_pkg::KIND_DIGITAL: kindTrig = digEdge;
      default:                    kindTrig = 1'b0;
    endcase
  end

  // fine-delay mode listens to its delayed software trigger only
  assign trigEv = cur.ctrl.fineDelayMode ? cur.fdFire : kindTrig;

  // fraction of the pacer period: fineDelay/256 of 2**divSel cycles
  assign fdSpan = {8'h00, cur.fineDelay} << cur.ctrl.divSel;

  // next-state logic
  always_comb begin
    next_cur           = cur;
    next_cur.mem.we    = 1'b0;
    next_cur.doneEv    = 1'b0;
    next_cur.armFirst  = 1'b0;
    next_cur.fdFire    = 1'b0;
    next_cur.rdata     = '0;
    next_cur.prevAbove = above;
    next_cur.prevPin   = pinSync;
    next_cur.prevExt   = extPacer;

    // register writes; setup only while idle
    if (busReq.wr && idle) begin
      unique case (busReq.addr)
        acq_trig_pkg::OFS_CTRL:
          next_cur.ctrl = acq_trig_pkg::ctrl_t'(busReq.wdata[acq_trig_pkg::CTRL_W-1:0]);
        acq_trig_pkg::OFS_THRESH:  next_cur.thresh    = busReq.wdata[7:0];
        acq_trig_pkg::OFS_FINEDLY: next_cur.fineDelay = busReq.wdata[7:0];
        acq_trig_pkg::OFS_START:
          next_cur.startCnt = busReq.wdata[23:0] & acq_trig_pkg::START_ALIGN_MASK;
        acq_trig_pkg::OFS_LENGTH:  next_cur.lenCnt    = busReq.wdata[23:0];
        acq_trig_pkg::OFS_POSTTRIG: begin
          // this write arms; about mode keeps the value but never uses it
          next_cur.postCnt  = busReq.wdata[23:0];
          next_cur.trigSeen = 1'b0;
          next_cur.wrapSeen = 1'b0;
          next_cur.pendTrig = 1'b0;
          next_cur.half     = 1'b0;
          if (cur.ctrl.aboutMode) begin
            next_cur.st = acq_trig_pkg::ST_PRE;
          end else begin
            next_cur.st       = acq_trig_pkg::ST_ARMED;
            next_cur.armFirst = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // fine-delay: software request waits for a pacer edge, then the delay
    if (cur.ctrl.fineDelayMode && (cur.st == acq_trig_pkg::ST_ARMED) && swTrig) begin
      next_cur.fdPend = 1'b1;
    end
    if (cur.fdPend && divTick) begin
      next_cur.fdPend = 1'b0;
      next_cur.fdRun  = 1'b1;
      next_cur.fdCnt  = fdSpan[acq_trig_pkg::FD_SHIFT_MSB:acq_trig_pkg::FD_SHIFT_LSB];
    end
    if (cur.fdRun) begin
      if (cur.fdCnt == 8'h00) begin
        next_cur.fdRun  = 1'b0;
        next_cur.fdFire = 1'b1;
      end else begin
        next_cur.fdCnt = cur.fdCnt - acq_trig_pkg::FD_ONE;
      end
    end

    // pair assembly: first sample held, second completes the word
    if (pacerTick && (sampling || (cur.st == acq_trig_pkg::ST_DELAY))) begin
      next_cur.half = !cur.half;
      if (!cur.half) begin
        next_cur.firstSample = sampleA;
      end
    end
    if (pairDone && sampling) begin
      next_cur.mem.we   = 1'b1;
      next_cur.mem.addr = cur.startCnt;
      next_cur.mem.data = {sampleA, cur.firstSample};
    end

    // acquisition sequence
    unique case (cur.st)
      acq_trig_pkg::ST_IDLE: ;
      acq_trig_pkg::ST_ARMED: begin
        if (trigEv) begin
          next_cur.st       = acq_trig_pkg::ST_DELAY;
          next_cur.trigLine = 1'b1;
          next_cur.trigSeen = 1'b1;
          next_cur.half     = 1'b0;
        end
      end
      acq_trig_pkg::ST_DELAY: begin
        if (cur.postCnt == '0) begin
          next_cur.st   = acq_trig_pkg::ST_RUN;
          next_cur.half = 1'b0;
        end else if (pairDone) begin
          next_cur.postCnt = cur.postCnt - acq_trig_pkg::CNT_ONE;
        end
      end
      acq_trig_pkg::ST_RUN: begin
        if (pairDone) begin
          if (cur.lenCnt == '0) begin
            // extra pair written, start left pointing at it
            next_cur.st       = acq_trig_pkg::ST_IDLE;
            next_cur.trigLine = 1'b0;
            next_cur.doneEv   = 1'b1;
          end else begin
            next_cur.lenCnt   = cur.lenCnt - acq_trig_pkg::CNT_ONE;
            next_cur.startCnt = startInc;
          end
        end
      end
      acq_trig_pkg::ST_PRE: begin
        if (pairDone) begin
          next_cur.startCnt = startInc;
          if (startInc == '0) begin
            next_cur.wrapSeen = 1'b1;
            next_cur.armFirst = 1'b1;
          end
        end
        if (cur.wrapSeen && trigEv) begin
          next_cur.pendTrig = 1'b1;
        end
        // accepted on the pacer edge
        if (pacerTick && cur.wrapSeen && (cur.pendTrig || trigEv)) begin
          next_cur.st       = acq_trig_pkg::ST_POST;
          next_cur.capture  = cur.startCnt;
          next_cur.pendTrig = 1'b0;
          next_cur.trigSeen = 1'b1;
          next_cur.trigLine = 1'b1;
        end
      end
      acq_trig_pkg::ST_POST: begin
        if (pairDone) begin
          next_cur.startCnt = startInc;
          if (cur.lenCnt == '0) begin
            next_cur.st       = acq_trig_pkg::ST_IDLE;
            next_cur.trigLine = 1'b0;
            next_cur.doneEv   = 1'b1;
          end else begin
            next_cur.lenCnt = cur.lenCnt - acq_trig_pkg::CNT_ONE;
          end
        end
      end
    endcase

    // pin: driven except in digital mode without fine delay, active level set by polarity
    next_cur.pinOut = next_cur.trigLine ^ next_cur.ctrl.negPol;
    next_cur.pinOeN = (next_cur.ctrl.kind == acq_trig_pkg::KIND_DIGITAL) &&
                      !next_cur.ctrl.fineDelayMode;

    // register reads, data in the following cycle only
    if (busReq.rd) begin
      unique case (busReq.addr)
        acq_trig_pkg::OFS_CTRL:     next_cur.rdata = 32'(cur.ctrl);
        acq_trig_pkg::OFS_THRESH:   next_cur.rdata = 32'(cur.thresh);
        acq_trig_pkg::OFS_FINEDLY:  next_cur.rdata = 32'(cur.fineDelay);
        acq_trig_pkg::OFS_START:    next_cur.rdata = 32'(cur.startCnt);
        acq_trig_pkg::OFS_LENGTH:   next_cur.rdata = 32'(cur.lenCnt);
        acq_trig_pkg::OFS_POSTTRIG: next_cur.rdata = 32'(cur.postCnt);
        acq_trig_pkg::OFS_CAPTURE:  next_cur.rdata = 32'(cur.capture);
        acq_trig_pkg::OFS_STATUS: begin
          next_cur.rdata[acq_trig_pkg::STAT_BUSY] = !idle;
          next_cur.rdata[acq_trig_pkg::STAT_TRIG] = cur.trigSeen;
          next_cur.rdata[acq_trig_pkg::STAT_WRAP] = cur.wrapSeen;
        end
        default: next_cur.rdata = '0;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cur <= acq_trig_pkg::CORE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // outputs
  assign busRdata   = cur.rdata;
  assign memWr      = cur.mem;
  assign trigPinOut = cur.pinOut;
  assign trigPinOeN = cur.pinOeN;
  assign busy       = !idle;
  assign acqDone    = cur.doneEv;

endmodule : acquisition_trigger_control

// >>> tb/acq_trig_asserts.sv
`timescale 1ns/1ps
module acq_trig_asserts (
  // clock and reset
  input wire logic                   core_clk,
  input wire logic                   rst,
  // register port
  input wire acq_trig_pkg::reg_req_t busReq,
  input wire logic [31:0]            busRdata,
  // pin, memory and status
  input wire logic                   trigPinOut,
  input wire logic                   trigPinOeN,
  input wire acq_trig_pkg::mem_wr_t  memWr,
  input wire logic                   busy,
  input wire logic                   acqDone
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // start load while idle, then a read of it
  sequence s_start_load;
    busReq.wr && busReq.addr == acq_trig_pkg::OFS_START && !busy;
  endsequence
  sequence s_start_read;
    busReq.rd && busReq.addr == acq_trig_pkg::OFS_START;
  endsequence

  a_start_align: assert property (s_start_load ##2 s_start_read |=>
    busRdata[1:0] == 2'b00 && busRdata[23:2] == $past(busReq.wdata[23:2], 3))
    else $error("start readback not pair aligned");
  a_rdata_idle: assert property (!$past(busReq.rd) |-> busRdata == 32'h0)
    else $error("read data outside answer cycle");
  a_arm_busy: assert property (busReq.wr && !busy &&
    busReq.addr == acq_trig_pkg::OFS_POSTTRIG |=> busy)
    else $error("post-trigger write did not arm");
  a_done_busy: assert property (acqDone |-> !busy && $past(busy))
    else $error("done pulse not at busy end");
  a_done_pulse: assert property (acqDone |=> !acqDone)
    else $error("done pulse longer than one cycle");
  a_we_even: assert property (memWr.we |-> !memWr.addr[0])
    else $error("pair write on odd address");
  a_we_pulse: assert property (memWr.we |=> !memWr.we)
    else $error("pair writes back to back");
  a_we_busy: assert property (!busy && !acqDone |-> !memWr.we)
    else $error("memory write while idle");
  a_pin_release: assert property ($fell(busy) && !trigPinOeN |->
    trigPinOut != $past(trigPinOut))
    else $error("trigger pin not released at end");
endmodule : acq_trig_asserts

// >>> tb/host_bus_model.sv
`timescale 1ns/1ps
module host_bus_model (
  // clock
  input wire logic                core_clk,
  // requests toward the device
  output acq_trig_pkg::reg_req_t busReq
);
  initial busReq = '0;

  // one strobe cycle, then release with inverted data
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    busReq <= '{a, d, w, ~w};
    @(posedge core_clk);
    busReq <= '{a, ~d, 1'b0, 1'b0};
  endtask : xfer

  // load settings, post-trigger count always last since it arms
  task automatic setup(input logic [31:0] ctrl, thr, start, len, post);
    xfer(1'b1, acq_trig_pkg::OFS_CTRL, ctrl);
    xfer(1'b1, acq_trig_pkg::OFS_THRESH, thr);
    xfer(1'b1, acq_trig_pkg::OFS_START, start);
    xfer(1'b1, acq_trig_pkg::OFS_LENGTH, len);
    xfer(1'b1, acq_trig_pkg::OFS_POSTTRIG, post);
  endtask : setup
endmodule : host_bus_model

// >>> tb/tb_acquisition_trigger_control.sv
`timescale 1ns/1ps
module tb_acquisition_trigger_control;
  logic                   core_clk;
  logic                   rst;
  acq_trig_pkg::reg_req_t busReq;
  logic [31:0]            busRdata;
  logic [7:0]             sampleA;
  logic [7:0]             sampleB;
  logic [7:0]             trigInCode;
  logic [7:0]             level;
  logic                   trigPinIn;
  logic                   trigPinOut;
  logic                   trigPinOeN;
  logic                   extDrive;
  logic                   busy;
  logic                   acqDone;
  logic                   rdSeen;
  logic                   fastPace;
  logic [7:0]             a0;
  logic [7:0]             a1;
  acq_trig_pkg::mem_wr_t  memWr;
  logic [1:0]             sel;
  logic [23:0]            nextAddr;
  logic [23:0]            memQ[$];
  logic [31:0]            rdQ[$];
  int                     seed = 65;
  int                     n_mismatch = 0;
  int                     checked = 0;
  int                     nWe = 0;

  // clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // shared trigger pin level
  assign trigPinIn = trigPinOeN ? extDrive : trigPinOut;

  acquisition_trigger_control DUT (
    .core_clk(core_clk), .rst(rst), .busReq(busReq), .busRdata(busRdata),
    .sampleA(sampleA), .sampleB(sampleB), .trigInCode(trigInCode), .extPacer(1'b0),
    .trigPinIn(trigPinIn), .trigPinOut(trigPinOut), .trigPinOeN(trigPinOeN),
    .memWr(memWr), .busy(busy), .acqDone(acqDone)
  );
  host_bus_model host (.core_clk(core_clk), .busReq(busReq));

  // selected input follows level, the others random
  always @(posedge core_clk) begin
    sampleA    <= (sel == 2'd0) ? level : 8'($random(seed));
    sampleB    <= (sel == 2'd1) ? level : 8'($random(seed));
    trigInCode <= (sel == 2'd2) ? level : 8'($random(seed));
    rdSeen     <= busReq.rd;
    a0         <= sampleA;
    a1         <= a0;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    host.xfer(1'b0, a, 32'h0);
  endtask : rd

  // wait bounded for idle, then count the pair writes
  task automatic acq(input int nExp);
    int k;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (busy !== 1'b0 && k < 40000);
    @(posedge core_clk);
    if (k >= 40000) begin
      n_mismatch++;
      give_verdict();
    end
    if (nExp >= 0) check(nWe, nExp);
    check(memQ.size(), 0);
    nWe = 0;
  endtask : acq

  // read answers and write addresses
  always @(negedge core_clk) begin
    if (rdSeen === 1'b1) check(busRdata, rdQ.size() ? rdQ.pop_front() : 32'hdeadbeef);
    if (memWr.we === 1'b1) begin
      check(memWr.addr, memQ.size() ? memQ.pop_front() : nextAddr);
      if (fastPace) check(memWr.data, {a0, a1});
      nextAddr = memWr.addr + 24'h2;
      nWe++;
    end
  end

  initial begin
    rst = 1'b1;
    sel = 2'd3;
    level = 8'h0;
    extDrive = 1'b0;
    rdSeen = 1'b0;
    fastPace = 1'b1;
    nextAddr = 24'h0;
    sampleA = 8'h0;
    sampleB = 8'h0;
    trigInCode = 8'h0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    // reset values, alignment, unmapped place
    rd(acq_trig_pkg::OFS_STATUS, 32'h0);
    rd(acq_trig_pkg::OFS_CTRL, 32'h0);
    host.xfer(1'b1, acq_trig_pkg::OFS_START, 32'h13);
    rd(acq_trig_pkg::OFS_START, 32'h10);
    host.xfer(1'b1, 8'h3c, 32'hffffffff);
    rd(8'h3c, 32'h0);
    $display("registers done");
    // post-trigger with software trigger and extra pair
    host.setup(32'h0, 32'h0, 32'h13, 32'h3, 32'h2);
    rd(acq_trig_pkg::OFS_STATUS, 32'h1);
    memQ = '{24'h10, 24'h12, 24'h14, 24'h16};
    host.xfer(1'b1, acq_trig_pkg::OFS_SWTRIG, 32'h0);
    acq(4);
    rd(acq_trig_pkg::OFS_START, 32'h16);
    $display("post soft done");
    // analog modes, sources and dividers
    fastPace = 1'b0;
    for (int i = 0; i < 8; i++) begin
      sel <= 2'(i % 3);
      level <= i[0] ? 8'h80 : 8'h81;
      memQ.push_back(24'h40);
      host.setup({20'h0, 3'(i), 2'b00, 2'(i % 3), i[1], i[0], 3'b010}, 32'h80, 32'h40,
                 32'h0, 32'd20);
      if (!i[1]) begin
        repeat (6) @(posedge core_clk);
        rd(acq_trig_pkg::OFS_STATUS, 32'h1);
        level <= i[0] ? 8'h81 : 8'h80;
        repeat (4) @(posedge core_clk);
        level <= i[0] ? 8'h80 : 8'h81;
      end
      repeat (6) @(posedge core_clk);
      check(trigPinOut, {31'h0, !i[0]});
      check(trigPinOeN, 32'h0);
      rd(acq_trig_pkg::OFS_STATUS, 32'h3);
      acq(1);
    end
    fastPace = 1'b1;
    $display("analog done");
    // digital edges on the pin
    sel <= 2'd3;
    for (int i = 0; i < 2; i++) begin
      extDrive <= i[0];
      memQ.push_back(24'h80);
      host.setup({28'h0, i[0], 3'b100}, 32'h0, 32'h80, 32'h0, 32'h0);
      repeat (6) @(posedge core_clk);
      check(trigPinOeN, 32'h1);
      rd(acq_trig_pkg::OFS_STATUS, 32'h1);
      extDrive <= ~i[0];
      acq(1);
    end
    $display("digital done");
    // fine delay: analog crossing ignored, software trigger taken
    sel <= 2'd0;
    level <= 8'h80;
    memQ.push_back(24'hc0);
    host.xfer(1'b1, acq_trig_pkg::OFS_FINEDLY, 32'h40);
    host.setup(32'h82, 32'h80, 32'hc0, 32'h0, 32'h0);
    repeat (4) @(posedge core_clk);
    level <= 8'hff;
    repeat (6) @(posedge core_clk);
    rd(acq_trig_pkg::OFS_STATUS, 32'h1);
    host.xfer(1'b1, acq_trig_pkg::OFS_SWTRIG, 32'h0);
    acq(1);
    $display("fine delay done");
    // about mode: early trigger ignored, wrap, capture
    sel <= 2'd3;
    memQ.push_back(24'hfffff8);
    host.setup(32'h1, 32'h0, 32'hfffff8, 32'h2, 32'h55);
    host.xfer(1'b1, acq_trig_pkg::OFS_SWTRIG, 32'h0);
    repeat (30) @(posedge core_clk);
    rd(acq_trig_pkg::OFS_STATUS, 32'h5);
    host.xfer(1'b1, acq_trig_pkg::OFS_SWTRIG, 32'h0);
    acq(-1);
    rd(acq_trig_pkg::OFS_START, {8'h0, nextAddr});
    rd(acq_trig_pkg::OFS_CAPTURE, {8'h0, nextAddr - 24'h8});
    $display("about done");
    give_verdict();
  end
endmodule : tb_acquisition_trigger_control

bind acquisition_trigger_control acq_trig_asserts chk (
  .core_clk, .rst, .busReq, .busRdata, .trigPinOut, .trigPinOeN, .memWr, .busy, .acqDone
);
